// ===== bench/tts_pins.sv
// Far-side pin model: count clocks, capture inputs and internal oscillator
`default_nettype none
module tts_pins (
    input  wire logic       i_clk,
    input  wire logic [5:0] i_fire,
    output logic      [5:0] o_pin,
    output logic            o_osc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt [6] = '{default: 3'h0};
    // Each request gives one pulse: 3 clocks high, then at least 3 low
    always_ff @(posedge i_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (i_fire[i]) cnt[i] <= 3'h6;
            else if (cnt[i] != 3'h0) cnt[i] <= cnt[i] - 3'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < 6; i++) o_pin[i] = (cnt[i] >= 3'h4);
    end
    // Oscillator slow enough for the synchroniser to see every edge
    initial begin
        o_osc = 1'b0;
        forever #61 o_osc = ~o_osc;
    end
endmodule
`default_nettype wire

// ===== bench/tts_timer_set_test.sv
// Self-checking bench for the three-channel timer set
`default_nettype none
module tts_timer_set_test;
    timeunit 1ns;
    timeprecision 100ps;
    import tts_pkg::*;
    typedef struct {string nm; int sel; logic [15:0] ex;} tts_note_t;
    logic        clk, osc, rst = 1'b1, stop = 1'b0;
    logic [2:0]  en = 3'h0, ack = 3'h0, irq;
    logic [1:0]  ms [3] = '{default: 2'h0};
    logic [2:0]  cs [3] = '{default: 3'h0};
    logic [15:0] ad [3] = '{default: 16'h0000};
    logic [15:0] bd [3] = '{default: 16'h0000};
    logic [7:0]  fsel = 8'h00, t0c, t0k;
    logic [5:0]  fire = 6'h00, pin;
    logic [15:0] t1c, t1k, t2c, t2k, a, p;
    logic        t0t, t0p, t1o, t1p, t2t, t2p;
    logic [15:0] obs [13];
    tts_note_t   q [$];
    int          fails = 0, tests_run = 0, k, n, seed = 32'h5d8e62d0;

    assign obs = '{16'(t0c), 16'(t0k), 16'(t0t), 16'(t0p), t1c, t1k, 16'(t1o), 16'(t1p),
                   t2c, t2k, 16'(t2t), 16'(t2p), 16'(irq)};

    tts_pins pins (.i_clk(clk), .i_fire(fire), .o_pin(pin), .o_osc(osc));

    tts_timer_set dut (
        .i_clk(clk), .i_sys_rst(rst), .i_stop_mode(stop),
        .i_timer0_enable(en[0]), .i_timer0_mode_select(ms[0]),
        .i_timer0_clock_select(cs[0]), .i_timer0_compare_data(ad[0][7:0]),
        .i_timer0_ext_clock(pin[0]), .i_timer0_capture_input(pin[3]),
        .i_timer1_enable(en[1]), .i_timer1_mode_select(ms[1]),
        .i_timer1_clock_select(cs[1]), .i_timer1_a_data(ad[1]), .i_timer1_b_data(bd[1]),
        .i_timer1_ext_clock(pin[1]), .i_timer1_capture_input(pin[4]),
        .i_timer2_enable(en[2]), .i_timer2_mode_select(ms[2]),
        .i_timer2_clock_select(cs[2]), .i_timer2_a_data(ad[2]), .i_timer2_b_data(bd[2]),
        .i_timer2_ext_clock(pin[2]), .i_timer2_capture_input(pin[5]),
        .i_port1_function_select_low(fsel), .i_high_speed_internal_osc(osc),
        .i_irq_ack(ack), .o_timer0_count(t0c), .o_timer0_capture_data(t0k),
        .o_timer0_toggle_out(t0t), .o_timer0_pwm_out(t0p), .o_timer1_count(t1c),
        .o_timer1_capture_data(t1k), .o_timer1_compare_out(t1o), .o_timer1_pwm_out(t1p),
        .o_timer2_count(t2c), .o_timer2_capture_data(t2k), .o_timer2_toggle_out(t2t),
        .o_timer2_pwm_out(t2p), .o_match_irq(irq)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check_val(string nm, logic [15:0] ex, logic [15:0] got);
        tests_run++;
        if (got !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic note(string nm, int sel, logic [15:0] ex);
        q.push_back('{nm, sel, ex});
    endtask

    // Results are taken from the queue once they have settled
    always @(negedge clk) begin
        tts_note_t m;
        while (q.size() > 0) begin
            m = q.pop_front();
            check_val(m.nm, m.ex, obs[m.sel]);
        end
    end

    task automatic tick(int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic pulse(int lane, int c);
        repeat (c) begin
            fire[lane] <= 1'b1;
            @(posedge clk);
            fire[lane] <= 1'b0;
            tick(9);
        end
    endtask

    task automatic setup(int t, logic [1:0] m, logic [2:0] c, logic [15:0] av,
                         logic [15:0] bv);
        en[t] <= 1'b0;
        ms[t] <= m;
        cs[t] <= c;
        ad[t] <= av;
        bd[t] <= bv;
        tick(2);
        en[t] <= 1'b1;
    endtask

    task automatic wait_for(int sel, logic [15:0] v);
        int w;
        w = 0;
        while (obs[sel] !== v && w < 700) begin
            @(posedge clk);
            #1;
            w++;
        end
        if (w == 700) note("wait", sel, v);
        @(posedge clk);
    endtask

    task automatic final_report();
        if (fails == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        tick(5);
        rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 13; i++) note("reset", i, 16'h0000);
        fsel <= 8'h50;
        setup(0, T0_COUNT, CKS_7, 16'h0002, 16'h0000);
        pulse(0, 2);
        note("t0 count", 0, 16'h0002);
        note("t0 toggle", 2, 16'h0000);
        pulse(0, 1);
        note("t0 toggle", 2, 16'h0001);
        note("t0 count", 0, 16'h0000);
        note("irq", 12, 16'h0001);
        ack <= 3'h1;
        tick(1);
        ack <= 3'h0;
        tick(2);
        note("irq", 12, 16'h0000);
        fsel <= 8'h00;
        for (int t = 0; t < 3; t++) begin
            k = 1 + ($random(seed) & 32'h7);
            setup(t, t == 0 ? 2'h2 : MODE_CAP, t == 2 ? CKS_6 : CKS_7, 16'h0, 16'h0);
            pulse(t, k);
            pulse(t + 3, 1);
            note("capture", 4 * t + 1, 16'(k));
        end
        fsel <= 8'h10;
        tick(2);
        pulse(1, 2);
        note("t1 gated", 4, 16'h0000);
        fsel <= 8'h50;
        a = 16'(3 + ($random(seed) & 32'hF));
        setup(2, MODE_COUNT, CKS_7, 16'hFFFF, 16'h0);
        setup(1, MODE_COUNT, 3'h0, a, 16'h0);
        // The count shows the compare value for two cycles per match
        n = 0;
        p = 16'h0000;
        repeat (200) begin
            @(posedge clk);
            #1;
            if (t1c === a && p === a) n++;
            p = t1c;
        end
        note("t1 compare out", 6, 16'(n & 1));
        tick(1);
        en[1] <= 1'b0;
        tick(8);
        note("t1 disabled", 4, 16'h0000);
        note("t2 on t1 match", 8, 16'(n));
        setup(1, MODE_COUNT, 3'h0, 16'hFFFF, 16'h0);
        setup(0, T0_COUNT, CKS_7, 16'h00FF, 16'h0);
        tick(4);
        stop <= 1'b1;
        tick(3);
        #1;
        a = t1c;
        tick(10);
        note("t1 stopped", 4, a);
        pulse(0, 2);
        note("t0 ext in stop", 0, 16'h0002);
        stop <= 1'b0;
        setup(2, MODE_ONE, 3'h1, 16'h0005, 16'h0003);
        wait_for(8, 16'h0001);
        note("t2 pwm", 11, 16'h0001);
        setup(0, T0_PWM, 3'h0, 16'h0080, 16'h0);
        setup(1, MODE_REP, 3'h0, 16'h0009, 16'h0004);
        for (int t = 0; t < 2; t++) begin
            wait_for(4 * t, t == 0 ? 16'h0010 : 16'h0002);
            note("pwm high", 4 * t + 3, 16'h0001);
            wait_for(4 * t, t == 0 ? 16'h00F0 : 16'h0007);
            note("pwm low", 4 * t + 3, 16'h0000);
        end
        note("one-shot count", 8, 16'h0000);
        note("one-shot pwm", 11, 16'h0000);
        tick(2);
        final_report();
    end

    initial begin
        #(25 * 20000);
        fails++;
        final_report();
    end
endmodule
`default_nettype wire

// ===== inc/tts_pkg.sv
// Shared constants and types for the three-channel timer set
`default_nettype none
package tts_pkg;
    localparam int          PRE_W       = 11;
    localparam int          T16_W       = 16;
    localparam int          SYNC_N      = 7;
    // Channel operating modes (2-bit encoding)
    localparam logic [1:0]  MODE_COUNT  = 2'h0;
    localparam logic [1:0]  MODE_CAP    = 2'h1;
    localparam logic [1:0]  MODE_ONE    = 2'h2;
    localparam logic [1:0]  MODE_REP    = 2'h3;
    // Timer 0 mode encodings
    localparam logic [1:0]  T0_COUNT    = 2'h0;
    localparam logic [1:0]  T0_PWM      = 2'h1;
    // Pin function select values and field positions
    localparam logic [1:0]  FSEL_OUT    = 2'h1;
    localparam logic [1:0]  FSEL_CAP    = 2'h0;
    localparam int          FSEL_T1_LSB = 4;
    localparam int          FSEL_T2_LSB = 6;
    // Clock select codes for non-prescaler sources (code 6 is the fx/2048 prescaler tap on timer 0)
    localparam logic [2:0]  CKS_6       = 3'h6;
    localparam logic [2:0]  CKS_7       = 3'h7;
    // Prescaler tap as log2 of divide ratio, indexed by clock select
    localparam logic [3:0]  T0_TAP [0:7] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'h0};
    localparam logic [3:0]  T1_TAP [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'hB, 4'h0, 4'h0};
    localparam logic [3:0]  T2_TAP [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h9, 4'h0, 4'h0};
    // Count limits and timer 0 PWM period
    localparam logic [15:0] LIM8        = 16'h00FF;
    localparam logic [15:0] LIM16       = 16'hFFFF;
    // Synchroniser lane indices
    localparam int          SY_EC0      = 0;
    localparam int          SY_EC1      = 1;
    localparam int          SY_EC2      = 2;
    localparam int          SY_CAP0     = 3;
    localparam int          SY_CAP1     = 4;
    localparam int          SY_CAP2     = 5;
    localparam int          SY_HSI      = 6;
    // Reset values
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_RST = 11'h000;

    typedef struct packed {
        logic [15:0] count;
        logic        pend;
        logic        evt;
        logic        done;
        logic        out;
        logic        pwm;
        logic        irq;
        logic [15:0] cap;
    } tts_ch_t;

    localparam tts_ch_t CH_RST = '{COUNT_RST, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, COUNT_RST};
endpackage
`default_nettype wire

// ===== rtl/tts_sync.sv
// Two-flop synchroniser bank with single-pulse rising edge detect
`default_nettype none
module tts_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_rise
);
    import tts_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } tts_sync_t;

    tts_sync_t st;
    tts_sync_t next_st;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("tts_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_comb begin
        next_st.s1 = i_async;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (i_sys_rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    // One pulse per rising edge, only from the settled flops
    assign o_rise = st.s2 & ~st.s3; // R20

    single_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // R20
        (o_rise != '0) |=> ((o_rise & $past(o_rise)) == '0))
        else $error("edge pulse lasted more than one cycle");
endmodule
`default_nettype wire

// ===== rtl/tts_timer_set.sv
// Three-channel timer set: 8-bit timer 0, 16-bit timers 1 and 2
// Contract
// R1: Timer 0 enabled: mode 00 counter, 01 PWM, 1X capture.
// R2: Timer 0 clock: fx/2..fx/2048 taps or its external clock pin.
// R3: Timer 0 capture mode latches count on each capture input event.
// R4: Timer 0 counter mode toggles its toggle pin on each compare match.
// R5: Timer 0 PWM mode drives waveform on its PWM pin.
// R6: Timer 1 modes 00 counter, 01 capture, 10 one-shot, 11 repeat; pin select gates.
// R7: Timer 1 clock: fx/1..fx/2048 taps, internal oscillator, or external pin.
// R8: Timer 1 capture mode latches 16-bit count on each capture event.
// R9: Timer 1 counter mode shows compare outcome on its compare pin.
// R10: Timer 1 pulse modes drive waveform on its PWM pin.
// R11: Timer 2 modes 00 counter, 01 capture, 10 one-shot, 11 repeat; pin select gates.
// R12: Timer 2 clock: fx/1..fx/512 taps, external pin, or timer 1 match.
// R13: Timer 2 capture mode latches 16-bit count on each capture event.
// R14: Timer 2 counter mode toggles its pin on each A data match.
// R15: Timer 2 pulse modes drive waveform on its PWM pin.
// R16: Match request flag stays set until acknowledged, then clears.
// R17: In stop state timers halt except those on an external clock.
// R18: Disabled timer holds counter at zero, restarts from zero on enable.
// R19: Counter clears the cycle after match and raises request then.
// R20: External inputs synchronised; one count or capture per edge.
`default_nettype none
module tts_timer_set (
    input  wire logic                       i_clk,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_stop_mode,
    input  wire logic                       i_timer0_enable,
    input  wire logic [1:0]                 i_timer0_mode_select,
    input  wire logic [2:0]                 i_timer0_clock_select,
    input  wire logic [7:0]                 i_timer0_compare_data,
    input  wire logic                       i_timer0_ext_clock,
    input  wire logic                       i_timer0_capture_input,
    input  wire logic                       i_timer1_enable,
    input  wire logic [1:0]                 i_timer1_mode_select,
    input  wire logic [2:0]                 i_timer1_clock_select,
    input  wire logic [tts_pkg::T16_W-1:0]  i_timer1_a_data,
    input  wire logic [tts_pkg::T16_W-1:0]  i_timer1_b_data,
    input  wire logic                       i_timer1_ext_clock,
    input  wire logic                       i_timer1_capture_input,
    input  wire logic                       i_timer2_enable,
    input  wire logic [1:0]                 i_timer2_mode_select,
    input  wire logic [2:0]                 i_timer2_clock_select,
    input  wire logic [tts_pkg::T16_W-1:0]  i_timer2_a_data,
    input  wire logic [tts_pkg::T16_W-1:0]  i_timer2_b_data,
    input  wire logic                       i_timer2_ext_clock,
    input  wire logic                       i_timer2_capture_input,
    input  wire logic [7:0]                 i_port1_function_select_low,
    input  wire logic                       i_high_speed_internal_osc,
    input  wire logic [2:0]                 i_irq_ack,
    output logic      [7:0]                 o_timer0_count,
    output logic      [7:0]                 o_timer0_capture_data,
    output logic                            o_timer0_toggle_out,
    output logic                            o_timer0_pwm_out,
    output logic      [tts_pkg::T16_W-1:0]  o_timer1_count,
    output logic      [tts_pkg::T16_W-1:0]  o_timer1_capture_data,
    output logic                            o_timer1_compare_out,
    output logic                            o_timer1_pwm_out,
    output logic      [tts_pkg::T16_W-1:0]  o_timer2_count,
    output logic      [tts_pkg::T16_W-1:0]  o_timer2_capture_data,
    output logic                            o_timer2_toggle_out,
    output logic                            o_timer2_pwm_out,
    output logic      [2:0]                 o_match_irq
);
    import tts_pkg::*;

    typedef struct packed {
        logic [PRE_W-1:0] pre;
        tts_ch_t          t0;
        tts_ch_t          t1;
        tts_ch_t          t2;
    } tts_state_t;

    tts_state_t        st;
    tts_state_t        next_st;
    logic [SYNC_N-1:0] rise;
    logic              t0_tick;
    logic              t1_tick;
    logic              t2_tick;
    logic              t0_run;
    logic              t1_run;
    logic              t2_run;
    logic [1:0]        t0_mode;
    logic [15:0]       t0_per;
    logic [15:0]       t0_duty;
    logic [1:0]        t1_fs;
    logic [1:0]        t2_fs;

    // True when the prescaler sits on the last count of a 2**l2 division
    function automatic logic tap_hit(input logic [PRE_W-1:0] pre, input logic [3:0] l2);
        logic [PRE_W-1:0] mask;
        mask = PRE_W'((12'h001 << l2) - 12'h001);
        return (pre & mask) == mask;
    endfunction

    // Pin function select must suit the mode for a 16-bit timer to run
    function automatic logic fs_ok(input logic [1:0] mode, input logic [1:0] fs);
        return (mode == MODE_CAP) ? (fs == FSEL_CAP) : (fs == FSEL_OUT);
    endfunction

    // One cycle of a channel: count, match, capture, pulse and request flag
    function automatic tts_ch_t step(input tts_ch_t     c,
                                     input logic        run,
                                     input logic        tick,
                                     input logic [1:0]  mode,
                                     input logic [15:0] per,
                                     input logic [15:0] duty,
                                     input logic [15:0] lim,
                                     input logic        cap,
                                     input logic        ack);
        tts_ch_t n;
        n = c;
        n.evt = 1'b0;
        if (!run) begin
            n.count = COUNT_RST; // R18
            n.pend = 1'b0;
            n.done = 1'b0;
            n.out = 1'b0;
            n.pwm = 1'b0;
        end else begin
            if (c.pend) begin
                n.count = COUNT_RST; // R19
                n.pend = 1'b0;
                n.evt = 1'b1;
                n.done = (mode == MODE_ONE);
            end else if (tick && !c.done) begin // R20
                if (mode == MODE_CAP) begin
                    n.count = (c.count == lim) ? COUNT_RST : 16'(c.count + 16'h0001);
                end else if (c.count == per) begin
                    n.pend = 1'b1;
                    n.out = (mode == MODE_COUNT) ? ~c.out : c.out; // R4 R9 R14
                end else begin
                    n.count = 16'(c.count + 16'h0001);
                end
            end
            if (cap && mode == MODE_CAP) begin
                n.cap = c.count; // R3 R8 R13
            end
            n.pwm = mode[1] && !n.done && (n.count < duty); // R5 R10 R15
        end
        // Set wins over acknowledge in the same cycle
        n.irq = n.evt | (c.irq & ~ack); // R16
        return n;
    endfunction

    // Taps reach 2**11 and the synchroniser carries seven lanes
    generate
        if (PRE_W < 11 || SYNC_N < 7) begin : g_chk
            $error("tts_timer_set: prescaler or synchroniser too narrow");
        end
    endgenerate

    tts_sync #(
        .WIDTH (SYNC_N)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_high_speed_internal_osc, i_timer2_capture_input,
                     i_timer1_capture_input, i_timer0_capture_input,
                     i_timer2_ext_clock, i_timer1_ext_clock, i_timer0_ext_clock}),
        .o_rise    (rise)
    );

    // Prescaler taps stop in the stop state; external pins keep counting
    assign t0_tick = (i_timer0_clock_select == CKS_7) ? rise[SY_EC0]
                   : (!i_stop_mode && tap_hit(st.pre, T0_TAP[i_timer0_clock_select])); // R2 R17
    assign t1_tick = (i_timer1_clock_select == CKS_7) ? rise[SY_EC1]
                   : (i_timer1_clock_select == CKS_6) ? (!i_stop_mode && rise[SY_HSI])
                   : (!i_stop_mode && tap_hit(st.pre, T1_TAP[i_timer1_clock_select])); // R7 R17
    assign t2_tick = (i_timer2_clock_select == CKS_7) ? st.t1.evt
                   : (i_timer2_clock_select == CKS_6) ? rise[SY_EC2]
                   : (!i_stop_mode && tap_hit(st.pre, T2_TAP[i_timer2_clock_select])); // R12 R17

    // Timer 0 mapped onto channel modes: PWM repeats over a 256-count period
    assign t0_mode = i_timer0_mode_select[1] ? MODE_CAP
                   : (i_timer0_mode_select == T0_PWM) ? MODE_REP : MODE_COUNT; // R1
    assign t0_per  = (t0_mode == MODE_REP) ? LIM8 : {8'h00, i_timer0_compare_data};
    assign t0_duty = {8'h00, i_timer0_compare_data};
    assign t0_run  = i_timer0_enable;
    assign t1_fs   = i_port1_function_select_low[FSEL_T1_LSB +: 2];
    assign t2_fs   = i_port1_function_select_low[FSEL_T2_LSB +: 2];
    assign t1_run  = i_timer1_enable && fs_ok(i_timer1_mode_select, t1_fs); // R6
    assign t2_run  = i_timer2_enable && fs_ok(i_timer2_mode_select, t2_fs); // R11

    always_comb begin
        next_st = st;
        next_st.pre = i_stop_mode ? st.pre : PRE_W'(st.pre + 11'h001);
        next_st.t0 = step(st.t0, t0_run, t0_tick, t0_mode, t0_per, t0_duty, LIM8,
                          rise[SY_CAP0], i_irq_ack[0]);
        next_st.t1 = step(st.t1, t1_run, t1_tick, i_timer1_mode_select, i_timer1_a_data,
                          i_timer1_b_data, LIM16, rise[SY_CAP1], i_irq_ack[1]);
        next_st.t2 = step(st.t2, t2_run, t2_tick, i_timer2_mode_select, i_timer2_a_data,
                          i_timer2_b_data, LIM16, rise[SY_CAP2], i_irq_ack[2]);
        if (i_sys_rst) begin
            next_st = '{PRE_RST, CH_RST, CH_RST, CH_RST};
        end
    end

    always_ff @(posedge i_clk) begin
        st <= next_st;
    end

    assign o_timer0_count        = st.t0.count[7:0];
    assign o_timer0_capture_data = st.t0.cap[7:0];
    assign o_timer0_toggle_out   = st.t0.out;
    assign o_timer0_pwm_out      = st.t0.pwm;
    assign o_timer1_count        = st.t1.count;
    assign o_timer1_capture_data = st.t1.cap;
    assign o_timer1_compare_out  = st.t1.out;
    assign o_timer1_pwm_out      = st.t1.pwm;
    assign o_timer2_count        = st.t2.count;
    assign o_timer2_capture_data = st.t2.cap;
    assign o_timer2_toggle_out   = st.t2.out;
    assign o_timer2_pwm_out      = st.t2.pwm;
    assign o_match_irq           = {st.t2.irq, st.t1.irq, st.t0.irq};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    t0_mode_map_a: assert property ( // R1
        i_timer0_mode_select[1] |-> t0_mode == MODE_CAP)
        else $error("timer 0 capture mode not selected");

    t0_prescale_a: assert property ( // R2
        (i_timer0_clock_select == 3'h0 && !i_stop_mode) |-> (t0_tick == st.pre[0]))
        else $error("timer 0 divide-by-2 tap wrong");

    t0_capture_a: assert property ( // R3
        (t0_run && t0_mode == MODE_CAP && rise[SY_CAP0] && $past(t0_run))
        |=> o_timer0_capture_data == $past(st.t0.count[7:0]))
        else $error("timer 0 capture value wrong");

    t0_toggle_a: assert property ( // R4
        (t0_run && t0_mode == MODE_COUNT && t0_tick && !st.t0.pend
         && st.t0.count == t0_per) |=> (o_timer0_toggle_out != $past(o_timer0_toggle_out)))
        else $error("timer 0 did not toggle on match");

    t0_pwm_a: assert property ( // R5
        (t0_run && t0_mode == MODE_REP) ##1 t0_run
        |-> o_timer0_pwm_out == (st.t0.count[7:0] < $past(i_timer0_compare_data)))
        else $error("timer 0 PWM level wrong");

    t1_fsel_a: assert property ( // R6
        (i_timer1_mode_select == MODE_CAP && t1_fs != FSEL_CAP) |=> st.t1.count == COUNT_RST)
        else $error("timer 1 ran with wrong pin select");

    t1_capture_a: assert property ( // R8
        (t1_run && i_timer1_mode_select == MODE_CAP && rise[SY_CAP1])
        |=> o_timer1_capture_data == $past(st.t1.count))
        else $error("timer 1 capture value wrong");

    t1_oneshot_a: assert property ( // R10
        st.t1.done |-> !o_timer1_pwm_out)
        else $error("one-shot pulse output active after finish");

    t2_capture_a: assert property ( // R13
        (t2_run && i_timer2_mode_select == MODE_CAP && rise[SY_CAP2])
        |=> o_timer2_capture_data == $past(st.t2.count))
        else $error("timer 2 capture value wrong");

    t2_clock_a: assert property ( // R12
        (i_timer2_clock_select == CKS_7) |-> (t2_tick == st.t1.evt))
        else $error("timer 2 not clocked by timer 1 match");

    irq_hold_a: assert property ( // R16
        (o_match_irq[1] && !i_irq_ack[1]) |=> o_match_irq[1])
        else $error("match request lost before acknowledge");

    stop_halt_a: assert property ( // R17
        (i_stop_mode && t1_run && i_timer1_clock_select != CKS_7 && !st.t1.pend)
        |=> $stable(st.t1.count))
        else $error("timer counted from prescaler in stop state");

    disable_zero_a: assert property ( // R18
        !i_timer2_enable |=> st.t2.count == COUNT_RST ##1 st.t2.count <= 16'h0001)
        else $error("disabled timer counter not held at zero");

    match_clear_a: assert property ( // R19
        (t1_run && st.t1.pend) ##1 t1_run |-> (st.t1.count == COUNT_RST && o_match_irq[1]))
        else $error("counter not cleared with request after match");

    t1_compare_a: assert property ( // R9
        (t1_run && i_timer1_mode_select == MODE_COUNT && t1_tick && !st.t1.pend
         && !st.t1.done && st.t1.count == i_timer1_a_data)
        |=> (o_timer1_compare_out != $past(o_timer1_compare_out)))
        else $error("timer 1 compare pin did not flip on match");

    t2_toggle_a: assert property ( // R14
        (t2_run && i_timer2_mode_select == MODE_COUNT && t2_tick && !st.t2.pend
         && !st.t2.done && st.t2.count == i_timer2_a_data)
        |=> (o_timer2_toggle_out != $past(o_timer2_toggle_out)))
        else $error("timer 2 did not toggle on match");

    t2_fsel_a: assert property ( // R11
        (i_timer2_mode_select != MODE_CAP && t2_fs != FSEL_OUT) |=> st.t2.count == COUNT_RST)
        else $error("timer 2 ran with wrong pin select");

    t1_osc_clock_a: assert property ( // R7
        (i_timer1_clock_select == CKS_6) |-> (t1_tick == (!i_stop_mode && rise[SY_HSI])))
        else $error("timer 1 oscillator clock source wrong");

    t0_pwm_c: cover property (t0_run && t0_mode == MODE_REP && $rose(o_timer0_pwm_out));
    t1_oneshot_c: cover property ($rose(st.t1.done));
    t2_chain_c: cover property (i_timer2_clock_select == CKS_7 && t2_tick && t2_run);
    t1_capture_c: cover property (t1_run && i_timer1_mode_select == MODE_CAP && rise[SY_CAP1]);
    irq_ack_c: cover property (o_match_irq[0] && i_irq_ack[0]);
endmodule
`default_nettype wire
